// ===== rcu_bench.sv
// Self-checking bench for the reset and clock control block.
// Assumes rcu_top and rcu_req_model; one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module reset_and_clock_control_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic fire = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_q;
    logic sys_rst_q, osc_enable_q, clk_out_en_q, clk_out_src_q, bus_clk_tick_q;
    logic ext_n, wwd, iwd, s0, s1, op_amp, pdh, lck, sby, adv, stb;
    logic [11:0] adc_d;
    logic sud = 1'b0, iwd_en = 1'b0, dl_en = 1'b0, dbg = 1'b0, sby_opt = 1'b0, pdc = 1'b0;
    logic icl, sgo;
    logic [31:0] prst_a;
    int miscompares = 0;
    int num_checks = 0;
    int k;
    int bits [10] = '{28, 28, 30, 29, 26, 23, 28, 25, 31, 22};
    always #25 clk_sys = ~clk_sys;
    rcu_req_model i_rcu_req_model (.clk_sys(clk_sys), .fire(fire), .sel(sel),
        .osc_enable_q(osc_enable_q), .ext_reset_pin_n(ext_n), .window_watchdog(wwd),
        .independent_watchdog(iwd), .soft_req_irq_cfg(s0), .soft_req_sys_ctl(s1),
        .op_amp_out(op_amp), .pd_hard_reset_rx(pdh), .core_lockup(lck),
        .standby_entry_done(sby), .adc_valid(adv), .adc_data(adc_d), .osc_stable(stb));
    rcu_top i_rcu_top (.clk_sys(clk_sys), .rst(rst), .supply_up_down_detector(sud),
        .ext_reset_pin_n(ext_n), .window_watchdog(wwd), .independent_watchdog(iwd),
        .independent_watchdog_enabled(iwd_en), .soft_req_irq_cfg(s0), .soft_req_sys_ctl(s1),
        .deadlock_reset_enable(dl_en), .core_lockup(lck), .debug_mode(dbg),
        .standby_reset_option(sby_opt), .stop_reset_option(1'b1), .standby_entry_done(sby),
        .shutdown_entry_done(1'b0), .op_amp_out(op_amp), .pd_hard_reset_rx(pdh),
        .pd_cable_reset_rx(pdc), .adc_valid(adv), .adc_data(adc_d), .adc_high(12'h800),
        .adc_low(12'h100), .osc_stable(stb), .osc_factory_calibration(8'h5A),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .sys_rst_q(sys_rst_q), .osc_enable_q(osc_enable_q),
        .osc_trim_q(), .osc_cal_q(), .bus_clk_tick_q(bus_clk_tick_q), .independent_watchdog_clk_en_q(icl),
        .clk_out_en_q(clk_out_en_q), .clk_out_src_q(clk_out_src_q), .standby_go_q(sgo),
        .shutdown_go_q(), .prst_ahb_q(prst_a), .prst_apb1_q(), .prst_apb2_q(), .pcen_ahb_q(),
        .pcen_apb1_q(), .pcen_apb2_q());
    ////////////////////////////////////////////////////////////////////////
    // Shared compare, bus cycles and bounded waits
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe, so sample it there
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata_q, exp);
    endtask
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        #1;
        // Sample clear of the launching edge so no race with the design's update
        while (sys_rst_q !== lvl && n < 200)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 200) complete_run(1);
    endtask
    task automatic complete_run(input bit hung);
        if (hung) miscompares++;
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic reset_values;
        wait_rst(1'b0);
        rd(rcu_pkg::OFS_CTLR, 32'h00005A83);
        rd(rcu_pkg::OFS_CAUSE, 32'h0C000000);
        rd(rcu_pkg::OFS_PCEN_AHB, 32'h00000014);
        rd(8'h08, 32'h0);
    endtask
    // Every model source, with its enables set and the flags cleared first
    task automatic each_source;
        for (k = 0; k < 10; k++)
        begin
            wr(rcu_pkg::OFS_RST_EN, 32'h0000000F);
            wr(rcu_pkg::OFS_CAUSE, 32'h01000000);
            @(posedge clk_sys);
            fire <= 1'b1; sel <= k[3:0];
            @(posedge clk_sys);
            fire <= 1'b0;
            wait_rst(1'b1);
            wait_rst(1'b0);
            rd(rcu_pkg::OFS_CAUSE, 32'h1 << bits[k]);
        end
    endtask
    task automatic osc_and_outputs;
        wr(rcu_pkg::OFS_CTLR, 32'h0000FF80);
        repeat (4) @(posedge clk_sys);
        rd(rcu_pkg::OFS_CTLR, 32'h00005A80);
        for (k = 0; k < 8; k++)
        begin
            wr(rcu_pkg::OFS_CFGR, k << 24);
            @(posedge clk_sys);
            #1 check({clk_out_en_q, clk_out_src_q}, {k == 4 || k == 5, k == 5});
        end
        wr(rcu_pkg::OFS_CFGR, 32'h00000030);
        @(posedge clk_sys);
        k = 0;
        repeat (40)
        begin
            @(posedge clk_sys);
            #1 k += bus_clk_tick_q;
        end
        check(k, 10);
    endtask
    // Supply event mid-run: all back to reset values; then the watchdog pins the oscillator
    task automatic power_and_watchdog;
        @(posedge clk_sys);
        sud <= 1'b1;
        @(posedge clk_sys);
        sud <= 1'b0;
        wait_rst(1'b0);
        check(prst_a, 32'h0);
        rd(rcu_pkg::OFS_CAUSE, 32'h0C000000);
        rd(rcu_pkg::OFS_CTLR, 32'h00005A83);
        @(posedge clk_sys);
        iwd_en <= 1'b1;
        wr(rcu_pkg::OFS_CTLR, 32'h00000080);
        @(posedge clk_sys);
        #1 check({osc_enable_q, icl}, 2'b11);
        @(posedge clk_sys);
        iwd_en <= 1'b0;
    endtask
    // Cable frames need their enable; debug or enable 1 masks deadlock; option 1 stands by
    task automatic masked_sources;
        for (k = 0; k < 2; k++)
        begin
            wr(rcu_pkg::OFS_RST_EN, k ? 32'h00000006 : 32'h00000002);
            wr(rcu_pkg::OFS_CAUSE, 32'h01000000);
            @(posedge clk_sys);
            pdc <= 1'b1;
            @(posedge clk_sys);
            pdc <= 1'b0;
            @(posedge clk_sys);
            #1 check(sys_rst_q, k);
            wait_rst(1'b0);
            rd(rcu_pkg::OFS_CAUSE, k ? 32'h10000000 : 32'h0);
        end
        for (k = 0; k < 2; k++)
        begin
            @(posedge clk_sys);
            dbg <= (k == 0);
            dl_en <= (k == 1);
            fire <= 1'b1;
            sel <= 4'h7;
            @(posedge clk_sys);
            fire <= 1'b0;
            repeat (6) @(posedge clk_sys);
            #1 check(sys_rst_q, 0);
        end
        @(posedge clk_sys);
        dbg <= 1'b0;
        dl_en <= 1'b0;
        sby_opt <= 1'b1;
        fire <= 1'b1;
        sel <= 4'h8;
        @(posedge clk_sys);
        fire <= 1'b0;
        @(posedge clk_sys);
        #1 check({sgo, sys_rst_q}, 2'b10);
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        reset_values();
        each_source();
        osc_and_outputs();
        power_and_watchdog();
        masked_sources();
        complete_run(0);
    end
endmodule // reset_and_clock_control_bench

`default_nettype wire

// ===== rcu_pkg.sv
// Constants for the reset and clock control block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 20 MHz system clock and a byte-addressed register port.
package rcu_pkg;

    // Clock and timing
    localparam int unsigned CLK_NS       = 50;
    localparam int unsigned RST_HOLD_NS  = 1000;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  RST_HOLD_CNT = 8'(RST_HOLD_CYC);
    localparam int unsigned OSC_KHZ      = 48000;
    localparam int unsigned OSC_OFF_PER  = 6;
    localparam int unsigned OSC_OFF_NS   = (OSC_OFF_PER * 1000000 + OSC_KHZ - 1) / OSC_KHZ;
    localparam int unsigned OSC_OFF_CYC  = (OSC_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  OSC_OFF_CNT  = 3'(OSC_OFF_CYC);

    // Register offsets
    localparam logic [7:0] OFS_CTLR      = 8'h00;
    localparam logic [7:0] OFS_CFGR      = 8'h04;
    localparam logic [7:0] OFS_PRST_APB2 = 8'h0C;
    localparam logic [7:0] OFS_PRST_APB1 = 8'h10;
    localparam logic [7:0] OFS_PCEN_AHB  = 8'h14;
    localparam logic [7:0] OFS_PCEN_APB2 = 8'h18;
    localparam logic [7:0] OFS_PCEN_APB1 = 8'h1C;
    localparam logic [7:0] OFS_CAUSE     = 8'h24;
    localparam logic [7:0] OFS_PRST_AHB  = 8'h28;
    localparam logic [7:0] OFS_RST_EN    = 8'h2C;

    // Clock control fields
    localparam int unsigned CTL_EN_BIT   = 0;
    localparam int unsigned CTL_RDY_BIT  = 1;
    localparam int unsigned CTL_TRIM_LSB = 3;
    localparam int unsigned CTL_CAL_LSB  = 8;
    localparam logic [4:0]  TRIM_RST     = 5'h10;

    // Clock configuration fields
    localparam int unsigned CFG_BUS_CLOCK_PRESCALER_LSB = 4;
    localparam int unsigned CFG_MCO_LSB  = 24;
    localparam logic [2:0]  MCO_SYS      = 3'h4;
    localparam logic [2:0]  MCO_OSC      = 3'h5;

    // Cause flags sit in bits 31:22; index 2 is the write-only clear bit
    localparam int unsigned CS_LSB     = 22;
    localparam int unsigned CS_CLR_BIT = 24;
    localparam int unsigned F_ADC      = 0;
    localparam int unsigned F_OPA      = 1;
    localparam int unsigned F_LOCK     = 3;
    localparam int unsigned F_PIN      = 4;
    localparam int unsigned F_POR      = 5;
    localparam int unsigned F_SW       = 6;
    localparam int unsigned F_INDEPENDENT_WATCHDOG     = 7;
    localparam int unsigned F_WINDOW_WATCHDOG     = 8;
    localparam int unsigned F_LPWR     = 9;
    localparam logic [9:0]  CS_RST     = 10'h030;

    // Reset source enables
    localparam int unsigned RE_OPA   = 0;
    localparam int unsigned RE_PD    = 1;
    localparam int unsigned RE_CABLE = 2;
    localparam int unsigned RE_ADC   = 3;

    // Peripheral clock enable reset value
    localparam logic [31:0] AHB_PCEN_RST = 32'h00000014;

endpackage

// ===== rcu_req_model.sv
// Partner model: reset requesters, watchdogs, ADC watchdog and oscillator.
// Assumes the bench pulses fire for one cycle with a source index in sel.
`timescale 1ns/10ps
`default_nettype none

module rcu_req_model (
    input  wire logic        clk_sys,
    input  wire logic        fire,
    input  wire logic [3:0]  sel,
    input  wire logic        osc_enable_q,
    output logic             ext_reset_pin_n,
    output logic             window_watchdog,
    output logic             independent_watchdog,
    output logic             soft_req_irq_cfg,
    output logic             soft_req_sys_ctl,
    output logic             op_amp_out,
    output logic             pd_hard_reset_rx,
    output logic             core_lockup,
    output logic             standby_entry_done,
    output logic             adc_valid,
    output logic      [11:0] adc_data,
    output logic             osc_stable
);
    logic [3:0] sel_q = 4'hF;
    logic [2:0] cnt_q = 3'h0;
    logic       lvl;
    logic       pls;
    // Levels last four cycles so the synchroniser filters accept them
    always_ff @(posedge clk_sys)
    begin
        if (fire)
        begin
            sel_q <= sel;
            cnt_q <= 3'h4;
        end
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    assign lvl = (cnt_q != 3'h0);
    assign pls = (cnt_q == 3'h4);
    // Each requester asserts only while selected
    assign soft_req_irq_cfg     = pls && sel_q == 4'h0;
    assign soft_req_sys_ctl     = pls && sel_q == 4'h1;
    assign window_watchdog      = lvl && sel_q == 4'h2;
    assign independent_watchdog = lvl && sel_q == 4'h3;
    assign ext_reset_pin_n      = !(lvl && sel_q == 4'h4);
    assign op_amp_out           = lvl && sel_q == 4'h5;
    assign pd_hard_reset_rx     = pls && sel_q == 4'h6;
    assign core_lockup          = lvl && sel_q == 4'h7;
    assign standby_entry_done   = pls && sel_q == 4'h8;
    assign adc_valid            = pls && sel_q == 4'h9;
    // Idle samples stay inside the thresholds, a valid one is above
    assign adc_data             = adc_valid ? 12'hFFF : 12'h400;
    // Oscillator settles with its enable and stops without it
    assign osc_stable           = osc_enable_q;
endmodule // rcu_req_model

`default_nettype wire

// ===== rcu_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes each input holds a level for at least three system clock cycles.
`timescale 1ns/10ps
`default_nettype none

module rcu_sync3 #(
    parameter int unsigned    W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout_q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] f;
    } rcu_sync_s;

    rcu_sync_s st_q;
    rcu_sync_s st_d;
    logic [W-1:0] agree;

    ////////////////////////////////////////////////////////////////////////
    // Only the second stage reads the first; the filter looks at 2 and 3
    always_comb
    begin
        st_d    = st_q;
        agree   = ~(st_q.s2 ^ st_q.s3);
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.f  = (st_q.s3 & agree) | (st_q.f & ~agree);
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            st_q <= '{s1: INIT, s2: INIT, s3: INIT, f: INIT};
        else
            st_q <= st_d;
    end

    assign dout_q = st_q.f;

endmodule // rcu_sync3

`default_nettype wire

// ===== rcu_top.sv
// Reset and clock control: merges reset sources, records the cause,
// manages the internal oscillator, bus prescaler, peripheral reset and
// clock gates, and clock output selection.
// Assumes one 20 MHz clock; the clock output mux sits outside this block.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module rcu_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        supply_up_down_detector,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        window_watchdog,
    input  wire logic        independent_watchdog,
    input  wire logic        independent_watchdog_enabled,
    input  wire logic        soft_req_irq_cfg,
    input  wire logic        soft_req_sys_ctl,
    input  wire logic        deadlock_reset_enable,
    input  wire logic        core_lockup,
    input  wire logic        debug_mode,
    input  wire logic        standby_reset_option,
    input  wire logic        stop_reset_option,
    input  wire logic        standby_entry_done,
    input  wire logic        shutdown_entry_done,
    input  wire logic        op_amp_out,
    input  wire logic        pd_hard_reset_rx,
    input  wire logic        pd_cable_reset_rx,
    input  wire logic        adc_valid,
    input  wire logic [11:0] adc_data,
    input  wire logic [11:0] adc_high,
    input  wire logic [11:0] adc_low,
    input  wire logic        osc_stable,
    input  wire logic [7:0]  osc_factory_calibration,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata_q,
    output logic             sys_rst_q,
    output logic             osc_enable_q,
    output logic      [4:0]  osc_trim_q,
    output logic      [7:0]  osc_cal_q,
    output logic             bus_clk_tick_q,
    output logic             independent_watchdog_clk_en_q,
    output logic             clk_out_en_q,
    output logic             clk_out_src_q,
    output logic             standby_go_q,
    output logic             shutdown_go_q,
    output logic      [31:0] prst_ahb_q,
    output logic      [31:0] prst_apb1_q,
    output logic      [31:0] prst_apb2_q,
    output logic      [31:0] pcen_ahb_q,
    output logic      [31:0] pcen_apb1_q,
    output logic      [31:0] pcen_apb2_q
);

    typedef struct packed {
        logic [7:0]  hold;
        logic        sys_rst;
        logic [9:0]  fl;
        logic        osc_en;
        logic        osc_rdy;
        logic [2:0]  off_cnt;
        logic [7:0]  cal;
        logic [4:0]  trim;
        logic [3:0]  bus_clock_prescaler;
        logic [2:0]  clock_output_select;
        logic [3:0]  div;
        logic        bus_tick;
        logic [3:0]  re;
        logic [31:0] prst_ahb;
        logic [31:0] prst_apb1;
        logic [31:0] prst_apb2;
        logic [31:0] pcen_ahb;
        logic [31:0] pcen_apb1;
        logic [31:0] pcen_apb2;
        logic [31:0] rdata;
        logic        independent_watchdog_clk;
        logic        stby_go;
        logic        shdn_go;
        logic        co_en;
        logic        co_src;
    } rcu_state_s;

    // Power reset leaves a system reset pending so calibration loads
    localparam rcu_state_s ST_RST = '{
        hold:     rcu_pkg::RST_HOLD_CNT,
        sys_rst:  1'b1,
        fl:       rcu_pkg::CS_RST,
        osc_en:   1'b1,
        osc_rdy:  1'b1,
        trim:     rcu_pkg::TRIM_RST,
        pcen_ahb: rcu_pkg::AHB_PCEN_RST,
        default:  '0
    };

    rcu_state_s st_q;
    rcu_state_s st_d;
    rcu_state_s nxt;
    logic       pwr_rst;
    logic [3:0] sync_q;
    logic       pin_s;
    logic       independent_watchdog_s;
    logic       opa_s;
    logic       stable_s;
    logic       sw_req;
    logic       lp_req;
    logic       lock_req;
    logic       opa_req;
    logic       pd_req;
    logic       adc_req;
    logic       any_req;
    logic [9:0] evt;
    logic       wr_ok;

    ////////////////////////////////////////////////////////////////////////
    // Power reset: external reset or the supply detector, both asynchronous
    assign pwr_rst = rst | supply_up_down_detector;

    // Asynchronous sources pass the filtered synchroniser
    rcu_sync3 #(
        .W    (4),
        .INIT (4'h9) // Idle levels: pin high, oscillator stable, no requests
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (pwr_rst),
        .din     ({osc_stable, op_amp_out, independent_watchdog, ext_reset_pin_n}),
        .dout_q  (sync_q)
    );

    assign pin_s    = sync_q[0];
    assign independent_watchdog_s   = sync_q[1];
    assign opa_s    = sync_q[2];
    assign stable_s = sync_q[3];

    ////////////////////////////////////////////////////////////////////////
    // Reset requests from every system source
    always_comb
    begin
        sw_req   = soft_req_irq_cfg | soft_req_sys_ctl;
        lp_req   = (standby_entry_done & ~standby_reset_option)
                 | (shutdown_entry_done & ~stop_reset_option);
        lock_req = core_lockup & ~deadlock_reset_enable & ~debug_mode;
        opa_req  = st_q.re[rcu_pkg::RE_OPA] & opa_s;
        pd_req   = st_q.re[rcu_pkg::RE_PD]
                 & (pd_hard_reset_rx
                    | (st_q.re[rcu_pkg::RE_CABLE] & pd_cable_reset_rx));
        adc_req  = st_q.re[rcu_pkg::RE_ADC] & adc_valid
                 & ((adc_data > adc_high) | (adc_data < adc_low));
        evt                    = '0;
        evt[rcu_pkg::F_ADC]    = adc_req;
        evt[rcu_pkg::F_OPA]    = opa_req;
        evt[rcu_pkg::F_LOCK]   = lock_req;
        evt[rcu_pkg::F_PIN]    = ~pin_s;
        evt[rcu_pkg::F_SW]     = sw_req | pd_req;
        evt[rcu_pkg::F_INDEPENDENT_WATCHDOG]   = independent_watchdog_s;
        evt[rcu_pkg::F_WINDOW_WATCHDOG]   = window_watchdog;
        evt[rcu_pkg::F_LPWR]   = lp_req;
        any_req  = |evt;
        wr_ok    = reg_wr & ~st_q.sys_rst;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: reset stretch, flags, oscillator, prescaler, registers
    always_comb
    begin
        st_d = st_q;
        nxt  = ST_RST;

        // Any request reloads the stretch; reset stays up until it drains
        if (any_req)
            st_d.hold = rcu_pkg::RST_HOLD_CNT;
        else if (st_q.hold != 8'h00)
            st_d.hold = st_q.hold - 8'h01;
        st_d.sys_rst = (st_d.hold != 8'h00);

        // Events win over a software clear arriving in the same cycle
        if (wr_ok && reg_addr == rcu_pkg::OFS_CAUSE && reg_wdata[rcu_pkg::CS_CLR_BIT])
            st_d.fl = '0;
        st_d.fl = st_d.fl | evt;

        // Register writes; ignored while the system is held in reset
        if (wr_ok)
        begin
            unique case (reg_addr)
                rcu_pkg::OFS_CTLR:
                begin
                    st_d.osc_en = reg_wdata[rcu_pkg::CTL_EN_BIT];
                    st_d.trim   = reg_wdata[rcu_pkg::CTL_TRIM_LSB +: 5];
                end
                rcu_pkg::OFS_CFGR:
                begin
                    st_d.bus_clock_prescaler = reg_wdata[rcu_pkg::CFG_BUS_CLOCK_PRESCALER_LSB +: 4];
                    st_d.clock_output_select  = reg_wdata[rcu_pkg::CFG_MCO_LSB +: 3];
                end
                rcu_pkg::OFS_PRST_AHB:  st_d.prst_ahb  = reg_wdata;
                rcu_pkg::OFS_PRST_APB1: st_d.prst_apb1 = reg_wdata;
                rcu_pkg::OFS_PRST_APB2: st_d.prst_apb2 = reg_wdata;
                rcu_pkg::OFS_PCEN_AHB:  st_d.pcen_ahb  = reg_wdata;
                rcu_pkg::OFS_PCEN_APB1: st_d.pcen_apb1 = reg_wdata;
                rcu_pkg::OFS_PCEN_APB2: st_d.pcen_apb2 = reg_wdata;
                rcu_pkg::OFS_RST_EN:    st_d.re        = reg_wdata[3:0];
                default:                st_d.re        = st_q.re;
            endcase
        end

        // The watchdog pins the oscillator on; a clear is simply lost
        if (independent_watchdog_enabled)
            st_d.osc_en = 1'b1;

        // Ready follows stability while on; falls a fixed delay after off
        if (st_q.osc_en)
        begin
            st_d.osc_rdy = stable_s;
            st_d.off_cnt = '0;
        end
        else if (st_q.osc_rdy)
        begin
            st_d.off_cnt = st_q.off_cnt + 3'h1;
            if (st_q.off_cnt + 3'h1 == rcu_pkg::OSC_OFF_CNT)
                st_d.osc_rdy = 1'b0;
        end

        // Bus clock tick every bus_clock_prescaler+1 system cycles
        if (st_q.div >= st_q.bus_clock_prescaler)
        begin
            st_d.div      = '0;
            st_d.bus_tick = 1'b1;
        end
        else
        begin
            st_d.div      = st_q.div + 4'h1;
            st_d.bus_tick = 1'b0;
        end

        // Low-power entry proceeds only where the option asks for it
        st_d.stby_go = standby_entry_done & standby_reset_option;
        st_d.shdn_go = shutdown_entry_done & stop_reset_option;

        // Read data stands in the cycle after the strobe only
        st_d.rdata = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                rcu_pkg::OFS_CTLR:      st_d.rdata = {16'h0000, st_q.cal, st_q.trim, 1'b0,
                                                      st_q.osc_rdy, st_q.osc_en};
                rcu_pkg::OFS_CFGR:      st_d.rdata = {5'h00, st_q.clock_output_select, 16'h0000,
                                                      st_q.bus_clock_prescaler, 4'h0};
                rcu_pkg::OFS_PRST_AHB:  st_d.rdata = st_q.prst_ahb;
                rcu_pkg::OFS_PRST_APB1: st_d.rdata = st_q.prst_apb1;
                rcu_pkg::OFS_PRST_APB2: st_d.rdata = st_q.prst_apb2;
                rcu_pkg::OFS_PCEN_AHB:  st_d.rdata = st_q.pcen_ahb;
                rcu_pkg::OFS_PCEN_APB1: st_d.rdata = st_q.pcen_apb1;
                rcu_pkg::OFS_PCEN_APB2: st_d.rdata = st_q.pcen_apb2;
                rcu_pkg::OFS_CAUSE:     st_d.rdata = {st_q.fl[9:3], 1'b0, st_q.fl[1:0],
                                                      22'h000000};
                rcu_pkg::OFS_RST_EN:    st_d.rdata = {28'h0000000, st_q.re};
                default:                st_d.rdata = '0;
            endcase
        end

        // System reset: defaults except flags, stretch, read data, oscillator ready and its off count; calibration loads, peripheral resets held
        if (st_q.sys_rst)
        begin
            nxt.hold    = st_d.hold;
            nxt.sys_rst = st_d.sys_rst;
            nxt.fl      = st_d.fl;
            nxt.rdata   = st_d.rdata;
            nxt.osc_rdy = st_d.osc_rdy;
            nxt.off_cnt = st_d.off_cnt;
            nxt.osc_en  = 1'b1;
            nxt.cal     = osc_factory_calibration;
            nxt.prst_ahb  = {32{st_d.sys_rst}};
            nxt.prst_apb1 = {32{st_d.sys_rst}};
            nxt.prst_apb2 = {32{st_d.sys_rst}};
            st_d = nxt;
        end

        // Clock output and watchdog clock follow live state, in reset too
        st_d.co_en    = (st_q.clock_output_select == rcu_pkg::MCO_SYS) | (st_q.clock_output_select == rcu_pkg::MCO_OSC);
        st_d.co_src   = (st_q.clock_output_select == rcu_pkg::MCO_OSC);
        st_d.independent_watchdog_clk = independent_watchdog_enabled & st_q.osc_rdy;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; power reset restores everything including flags
    always_ff @(posedge clk_sys or posedge pwr_rst)
    begin
        if (pwr_rst)
            st_q <= ST_RST;
        else
            st_q <= st_d;
    end

    // Outputs straight from state flops
    assign reg_rdata_q    = st_q.rdata;
    assign sys_rst_q      = st_q.sys_rst;
    assign osc_enable_q   = st_q.osc_en;
    assign osc_trim_q     = st_q.trim;
    assign osc_cal_q      = st_q.cal;
    assign bus_clk_tick_q = st_q.bus_tick;
    assign independent_watchdog_clk_en_q  = st_q.independent_watchdog_clk;
    assign clk_out_en_q   = st_q.co_en;
    assign clk_out_src_q  = st_q.co_src;
    assign standby_go_q   = st_q.stby_go;
    assign shutdown_go_q  = st_q.shdn_go;
    assign prst_ahb_q     = st_q.prst_ahb;
    assign prst_apb1_q    = st_q.prst_apb1;
    assign prst_apb2_q    = st_q.prst_apb2;
    assign pcen_ahb_q     = st_q.pcen_ahb;
    assign pcen_apb1_q    = st_q.pcen_apb1;
    assign pcen_apb2_q    = st_q.pcen_apb2;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (pwr_rst);

    a_req_to_reset:
        assert property (any_req |=> sys_rst_q)
        else $error("reset request did not raise system reset");

    a_reset_min_hold:
        assert property ($rose(sys_rst_q) |-> sys_rst_q[*8])
        else $error("system reset shorter than minimum");

    a_flags_kept:
        assert property (sys_rst_q |=> (st_q.fl & $past(st_q.fl)) == $past(st_q.fl))
        else $error("cause flag lost during system reset");

    a_pd_soft_flag:
        assert property (pd_req |=> st_q.fl[rcu_pkg::F_SW] && sys_rst_q)
        else $error("power-delivery reset without software flag");

    a_deadlock_reset:
        assert property (core_lockup && !deadlock_reset_enable && !debug_mode
                         |=> st_q.fl[rcu_pkg::F_LOCK] ##1 sys_rst_q)
        else $error("deadlock did not reset");

    a_osc_forced:
        assert property (independent_watchdog_enabled |=> osc_enable_q
                         && independent_watchdog_clk_en_q == $past(st_q.osc_rdy))
        else $error("oscillator not forced on by watchdog");

    a_ready_falls:
        assert property ($fell(osc_enable_q) && st_q.osc_rdy ##1 (!osc_enable_q)[*2]
                         |=> !st_q.osc_rdy)
        else $error("ready flag did not fall after disable");

    a_cal_loaded:
        assert property (sys_rst_q |=> osc_cal_q == $past(osc_factory_calibration))
        else $error("calibration not loaded on reset");

    a_clkout_sel:
        assert property (st_q.clock_output_select == rcu_pkg::MCO_SYS |=> clk_out_en_q && !clk_out_src_q)
        else $error("clock output select misdecoded");

    a_ctl_readback:
        assert property (reg_rd && reg_addr == rcu_pkg::OFS_CTLR
                         |=> reg_rdata_q[1:0] == $past({st_q.osc_rdy, st_q.osc_en}))
        else $error("clock control readback wrong");

endmodule // rcu_top

`default_nettype wire
